// File: logic/wdp_pkg.sv
// package of constants for the watchdog with postscaler
// assumes a 10 MHz system clock and a plain byte-wide register port
package wdp_pkg;

  // ==========================================================
  // register port geometry
  localparam int ADDR_W = 22;             // byte address width
  localparam int DATA_W = 8;              // register width

  // ==========================================================
  // register offsets
  localparam logic [21:0] OFS_CFG_ENABLE = 22'h300000; // config enable byte
  localparam logic [21:0] OFS_POSTSCALE = 22'h300003;  // watchdog_postscale_config
  localparam logic [21:0] OFS_CONTROL = 22'h300010;    // watchdog_control
  localparam logic [21:0] OFS_STATUS = 22'h300011;     // live status, read only

  // ==========================================================
  // field positions
  localparam int CTL_SOFT_EN_BIT = 0;     // soft_watchdog_enable
  localparam int CTL_REG_LP_BIT = 7;      // regulator_sleep_lowpower
  localparam int CFG_EN_BIT = 0;          // config_watchdog_enable
  localparam int TAP_W = 4;               // timeout_tap_select width
  localparam int STS_ENABLED_BIT = 0;     // watchdog running
  localparam int STS_RC_BIT = 1;          // internal RC requested
  localparam int STS_LP_BIT = 2;          // regulator in low power now
  localparam int STS_LOCK_BIT = 3;        // select field already written

  // ==========================================================
  // reset and read-back values
  localparam logic [3:0] TAP_UNPROG = 4'hF;     // unprogrammed select
  localparam logic [3:0] CFG_UPPER_ONES = 4'hF; // upper nibble reads ones
  localparam logic CFG_EN_UNPROG = 1'b1;        // unprogrammed enable
  localparam logic [7:0] CTL_RESET = 8'h00;     // control after any reset
  localparam logic [7:0] READ_ZERO = 8'h00;     // unmapped or empty read

  // ==========================================================
  // postscaler and timing
  localparam int POST_W = 16;             // postscaler width
  localparam int CLK_PERIOD_NS = 100;     // 10 MHz system clock
  localparam int BASE_PERIOD_NS = 4000000; // 4 ms nominal base period
  localparam int BASE_CYCLES = BASE_PERIOD_NS / CLK_PERIOD_NS;
  localparam int BASE_CNT_W = 16;         // base counter width

endpackage

// File: logic/wdp_postscaler.sv
// 16-bit watchdog postscaler with a tap multiplexer
// assumes base_tick is a one-cycle pulse in the clk domain
`timescale 1ns/10ps

module wdp_postscaler (
  input wire logic clk,
  input wire logic rst,
  input wire logic clear,
  input wire logic base_tick,
  input wire logic [3:0] tap_sel,
  output logic tap_hit,
  output logic [15:0] count
);

  // ==========================================================
  // state
  logic [15:0] count_r;                   // postscaler count
  logic [15:0] count_nxt;                 // next count
  logic [16:0] carry;                     // tap n fires when low n bits all ones

  // ==========================================================
  // tap chain: tap n pulses once every two to the n base ticks
  assign carry[0] = base_tick;
  genvar gi;
  generate
    for (gi = 0; gi < wdp_pkg::POST_W; gi++) begin : g_tap
      assign carry[gi + 1] = carry[gi] & count_r[gi];
    end
  endgenerate

  // selected tap is the timeout event
  assign tap_hit = carry[tap_sel];
  assign count = count_r;

  // next count: clear has priority over counting
  always_comb begin
    count_nxt = count_r;
    if (clear) begin
      count_nxt = '0;
    end else if (base_tick) begin
      count_nxt = count_r + 16'h0001;
    end
  end

  // register the count
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count_r <= '0;
    end else begin
      count_r <= count_nxt;
    end
  end

endmodule

// File: logic/wdp_watchdog.sv
// watchdog top: base counter, postscaler, config and control registers
// assumes rst is power-on reset, core strobes are clk-domain pulses,
// and the low-voltage detect arrives asynchronously from the analog side
//
// Design decision made here: strobed register access.
`timescale 1ns/10ps

module wdp_watchdog #(
  parameter int BASE_CYCLES = wdp_pkg::BASE_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic sys_reset,
  input wire logic [21:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic sleep_instr,
  input wire logic clear_watchdog_instr,
  input wire logic clock_fail,
  input wire logic in_sleep,
  input wire logic low_voltage_detect,
  output logic internal_rc_clock_en,
  output logic regulator_lowpower,
  output logic watchdog_reset,
  output logic watchdog_wake
);

  // ==========================================================
  // declarations
  // low-voltage detect synchroniser
  logic lvd_meta_r;                       // first synchroniser stage
  logic lvd_sync_r;                       // second synchroniser stage

  // configuration state, cleared only by power-on reset
  logic [3:0] tap_sel_r;                  // timeout_tap_select
  logic [3:0] tap_sel_nxt;
  logic tap_lock_r;                       // select field written once
  logic tap_lock_nxt;
  logic cfg_en_r;                         // config_watchdog_enable
  logic cfg_en_nxt;
  logic cfg_en_lock_r;                    // enable byte written once
  logic cfg_en_lock_nxt;

  // control register state
  logic soft_en_r;                        // soft_watchdog_enable
  logic soft_en_nxt;
  logic reg_lp_r;                         // regulator_sleep_lowpower
  logic reg_lp_nxt;

  // base period divider
  logic [15:0] base_cnt_r;                // base period counter
  logic [15:0] base_cnt_nxt;
  logic base_tick;                        // one pulse per base period

  // read path
  logic [7:0] rdata_r;                    // registered read data
  logic [7:0] rdata_nxt;

  // timeout pulses
  logic wdt_reset_r;                      // timeout reset pulse
  logic wdt_reset_nxt;
  logic wdt_wake_r;                       // timeout wake pulse
  logic wdt_wake_nxt;

  // enable and clear glue
  logic wd_enabled;                       // watchdog running
  logic count_clear;                      // clears base and postscaler
  logic tap_hit;                          // selected postscaler output
  logic [15:0] base_last;                 // base counter terminal value

  // decoded strobes
  logic wr_cfg_en;
  logic wr_tap;
  logic wr_ctl;

  // ==========================================================
  // low-voltage detect synchroniser
  // only the second stage is read; the first one may settle late
  // a detect shorter than about one clock may be missed
  // the detect is a level, so a lasting condition is always seen
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lvd_meta_r <= 1'b0;
      lvd_sync_r <= 1'b0;
    end else begin
      lvd_meta_r <= low_voltage_detect;
      lvd_sync_r <= lvd_meta_r;
    end
  end

  // ==========================================================
  // address decode
  // exact match, so no alias of a config byte can lock it by accident
  assign wr_cfg_en = reg_wr && (reg_addr == wdp_pkg::OFS_CFG_ENABLE);
  assign wr_tap = reg_wr && (reg_addr == wdp_pkg::OFS_POSTSCALE);
  assign wr_ctl = reg_wr && (reg_addr == wdp_pkg::OFS_CONTROL);

  // ==========================================================
  // configuration bytes: survive every reset but power-on
  // a lock per byte keeps software from shortening a timeout later
  always_comb begin
    tap_sel_nxt = tap_sel_r;
    tap_lock_nxt = tap_lock_r;
    cfg_en_nxt = cfg_en_r;
    cfg_en_lock_nxt = cfg_en_lock_r;
    // first write of the power cycle sticks, later ones ignored
    if (wr_tap && !tap_lock_r) begin
      tap_sel_nxt = reg_wdata[wdp_pkg::TAP_W-1:0];
      tap_lock_nxt = 1'b1;
    end
    // enable byte is write-once in the same way
    if (wr_cfg_en && !cfg_en_lock_r) begin
      cfg_en_nxt = reg_wdata[wdp_pkg::CFG_EN_BIT];
      cfg_en_lock_nxt = 1'b1;
    end
  end

  // only power-on reset touches the config state
  // sys_reset is deliberately not looked at here
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tap_sel_r <= wdp_pkg::TAP_UNPROG;
      tap_lock_r <= 1'b0;
      cfg_en_r <= wdp_pkg::CFG_EN_UNPROG;
      cfg_en_lock_r <= 1'b0;
    end else begin
      tap_sel_r <= tap_sel_nxt;
      tap_lock_r <= tap_lock_nxt;
      cfg_en_r <= cfg_en_nxt;
      cfg_en_lock_r <= cfg_en_lock_nxt;
    end
  end

  // ==========================================================
  // control register
  // sys_reset acts like any non-power-on reset: control back to zero
  // a detect clears the regulator bit even against a same-cycle write
  always_comb begin
    soft_en_nxt = soft_en_r;
    reg_lp_nxt = reg_lp_r;
    if (sys_reset) begin
      // any other reset returns control to its reset value
      soft_en_nxt = wdp_pkg::CTL_RESET[wdp_pkg::CTL_SOFT_EN_BIT];
      reg_lp_nxt = wdp_pkg::CTL_RESET[wdp_pkg::CTL_REG_LP_BIT];
    end else begin
      if (wr_ctl) begin
        soft_en_nxt = reg_wdata[wdp_pkg::CTL_SOFT_EN_BIT];
        reg_lp_nxt = reg_wdata[wdp_pkg::CTL_REG_LP_BIT];
      end
      // detect wins over a write in the same cycle
      if (lvd_sync_r) begin
        reg_lp_nxt = 1'b0;
      end
    end
  end

  // register control bits
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      soft_en_r <= wdp_pkg::CTL_RESET[wdp_pkg::CTL_SOFT_EN_BIT];
      reg_lp_r <= wdp_pkg::CTL_RESET[wdp_pkg::CTL_REG_LP_BIT];
    end else begin
      soft_en_r <= soft_en_nxt;
      reg_lp_r <= reg_lp_nxt;
    end
  end

  // ==========================================================
  // enable and clock request
  // config enable forces on; software only matters when it is clear
  assign wd_enabled = cfg_en_r | soft_en_r;
  // RC oscillator runs whenever the watchdog does
  assign internal_rc_clock_en = wd_enabled;
  // regulator drops to low power only while asleep with the bit set
  assign regulator_lowpower = reg_lp_r & in_sleep;

  // counts restart on sleep, clear, clock failure, reset or disable
  // zero counts while off mean that enabling starts a full period
  assign count_clear = sleep_instr | clear_watchdog_instr
                     | clock_fail
                     | sys_reset | !wd_enabled;

  // ==========================================================
  // base counter: divides the system clock into 4 ms periods
  // no tick in a clear cycle, so a clear never races a pending timeout
  assign base_last = 16'(BASE_CYCLES - 1);
  assign base_tick = wd_enabled && !count_clear && (base_cnt_r == base_last);

  always_comb begin
    base_cnt_nxt = base_cnt_r;
    if (count_clear) begin
      base_cnt_nxt = '0;
    end else if (base_tick) begin
      base_cnt_nxt = '0;
    end else begin
      base_cnt_nxt = base_cnt_r + 16'h0001;
    end
  end

  // register base count
  // the 16-bit counter bounds BASE_CYCLES to 65536
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      base_cnt_r <= '0;
    end else begin
      base_cnt_r <= base_cnt_nxt;
    end
  end

  // ==========================================================
  // postscaler with tap select
  // running count left open: only the selected tap matters here
  wdp_postscaler u_post (
    .clk(clk),
    .rst(rst),
    .clear(count_clear),
    .base_tick(base_tick),
    .tap_sel(tap_sel_r),
    .tap_hit(tap_hit),
    .count()
  );

  // ==========================================================
  // timeout outputs: one-cycle pulses
  // registered so the core sees one clean request per timeout
  // sleep state is taken in the cycle in which the tap fires
  // a tap that fires again after a wrap gives a fresh pulse
  always_comb begin
    wdt_reset_nxt = 1'b0;
    wdt_wake_nxt = 1'b0;
    if (tap_hit && wd_enabled) begin
      // asleep: wake the core, awake: reset it
      if (in_sleep) begin
        wdt_wake_nxt = 1'b1;
      end else begin
        wdt_reset_nxt = 1'b1;
      end
    end
  end

  // register timeout pulses
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wdt_reset_r <= 1'b0;
      wdt_wake_r <= 1'b0;
    end else begin
      wdt_reset_r <= wdt_reset_nxt;
      wdt_wake_r <= wdt_wake_nxt;
    end
  end

  assign watchdog_reset = wdt_reset_r;
  assign watchdog_wake = wdt_wake_r;

  // ==========================================================
  // read path: data stands only in the cycle after the strobe
  // idle cycles read zero, so stale data is never mistaken for a reply
  always_comb begin
    rdata_nxt = wdp_pkg::READ_ZERO;
    if (reg_rd) begin
      case (reg_addr)
        wdp_pkg::OFS_CFG_ENABLE: begin
          // enable byte, other bits zero
          rdata_nxt[wdp_pkg::CFG_EN_BIT] = cfg_en_r;
        end
        wdp_pkg::OFS_POSTSCALE: begin
          // upper nibble reads as ones
          rdata_nxt = {wdp_pkg::CFG_UPPER_ONES, tap_sel_r};
        end
        wdp_pkg::OFS_CONTROL: begin
          // bits 6..1 stay zero
          rdata_nxt[wdp_pkg::CTL_SOFT_EN_BIT] = soft_en_r;
          rdata_nxt[wdp_pkg::CTL_REG_LP_BIT] = reg_lp_r;
        end
        wdp_pkg::OFS_STATUS: begin
          // live view of the block
          // read only: a write to this address matches no strobe
          rdata_nxt[wdp_pkg::STS_ENABLED_BIT] = wd_enabled;
          rdata_nxt[wdp_pkg::STS_RC_BIT] = internal_rc_clock_en;
          rdata_nxt[wdp_pkg::STS_LP_BIT] = regulator_lowpower;
          rdata_nxt[wdp_pkg::STS_LOCK_BIT] = tap_lock_r;
        end
        default: begin
          // unmapped reads return zero
          rdata_nxt = wdp_pkg::READ_ZERO;
        end
      endcase
    end
  end

  // register read data
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_r <= wdp_pkg::READ_ZERO;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign reg_rdata = rdata_r;

endmodule

// File: test/tb.sv
// testbench: register port, timeout taps, clear sources, regulator bit
// assumes wdp_pkg, the design and the bound checker are compiled first
`timescale 1ns/10ps

module tb;
  // ==========================================================
  // signals and tap table
  localparam int BC = 4; // shortened base period
  logic clk, rst, sys_reset, reg_wr, reg_rd, sleep_instr, clear_watchdog_instr;
  logic clock_fail, in_sleep, low_voltage_detect, rc_en, reg_lp, wd_rst, wd_wake;
  logic [21:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata;
  int n_fail = 0;
  int n_tests = 0;
  int n;
  // rows: tap code, then expected config read-back
  logic [11:0] rows [6] = '{12'h0F0, 12'h2F2, 12'h3F3, 12'h6F6, 12'hAFA, 12'h1F1};

  wdp_watchdog #(.BASE_CYCLES(BC)) u_dut (
    .clk(clk), .rst(rst), .sys_reset(sys_reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .sleep_instr(sleep_instr), .clear_watchdog_instr(clear_watchdog_instr),
    .clock_fail(clock_fail), .in_sleep(in_sleep), .low_voltage_detect(low_voltage_detect),
    .internal_rc_clock_en(rc_en), .regulator_lowpower(reg_lp),
    .watchdog_reset(wd_rst), .watchdog_wake(wd_wake)
  );

  // clock, 100 ns period
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // ==========================================================
  // tasks
  task automatic cyc; // just after a rising edge
    @(posedge clk);
    #1;
  endtask
  task automatic stop_test;
    $display("comparisons %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(logic [31:0] got, logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %0h, expected %0h", $time, got, exp);
    end
  endtask
  task automatic por; // power-on reset, config back to ones
    cyc();
    rst <= 1'b1;
    repeat (5) cyc();
    rst <= 1'b0;
    cyc();
  endtask
  task automatic wr(logic [21:0] a, logic [7:0] v);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    cyc();
    reg_wr <= 1'b0;
    cyc();
  endtask
  task automatic rd_chk(logic [21:0] a, logic [7:0] exp);
    reg_addr <= a;
    reg_rd <= 1'b1;
    cyc();
    reg_rd <= 1'b0;
    chk(reg_rdata, exp);
    cyc();
  endtask
  task automatic kick(int k); // 0 clear, 1 sleep, 2 clock fail, 3 sys reset
    clear_watchdog_instr <= (k == 0);
    sleep_instr <= (k == 1);
    clock_fail <= (k == 2);
    sys_reset <= (k == 3);
    cyc();
    {clear_watchdog_instr, sleep_instr, clock_fail, sys_reset} <= 4'h0;
  endtask
  task automatic expect_to(int exp, logic [1:0] kind); // cycles from kick cycle to pulse
    cyc();
    for (n = 1; n < 70000; n++) begin
      cyc();
      if ((wd_rst | wd_wake) === 1'b1) break;
    end
    if (n >= 70000) begin
      n_fail++;
      stop_test();
    end else begin
      // loop index n stands for the clock edge n + 1 after the kick edge
      chk(n + 2, exp);
      chk({wd_rst, wd_wake}, kind);
    end
  endtask

  // ==========================================================
  // main sequence
  initial begin
    {rst, sys_reset, reg_wr, reg_rd, sleep_instr} = 5'h10;
    {clear_watchdog_instr, clock_fail, in_sleep, low_voltage_detect} = 4'h0;
    reg_addr = 22'h000000;
    reg_wdata = 8'h00;
    // one power cycle per tap, since the select is write-once
    foreach (rows[i]) begin
      por();
      rd_chk(wdp_pkg::OFS_POSTSCALE, 8'hFF);
      rd_chk(wdp_pkg::OFS_CFG_ENABLE, 8'h01);
      rd_chk(wdp_pkg::OFS_STATUS, 8'h03);
      chk(rc_en, 1'b1);
      wr(wdp_pkg::OFS_POSTSCALE, {4'h0, rows[i][11:8]});
      wr(wdp_pkg::OFS_POSTSCALE, 8'h05);
      rd_chk(wdp_pkg::OFS_POSTSCALE, rows[i][7:0]);
      kick(0);
      expect_to((1 << rows[i][11:8]) * BC + 1, 2'b10);
    end
    // control register and regulator bit
    rd_chk(wdp_pkg::OFS_CONTROL, 8'h00);
    rd_chk(22'h000123, 8'h00);
    wr(wdp_pkg::OFS_CONTROL, 8'hFF);
    rd_chk(wdp_pkg::OFS_CONTROL, 8'h81);
    in_sleep <= 1'b1;
    cyc();
    chk(reg_lp, 1'b1);
    rd_chk(wdp_pkg::OFS_STATUS, 8'h0F);
    low_voltage_detect <= 1'b1;
    repeat (4) cyc();
    chk(reg_lp, 1'b0);
    low_voltage_detect <= 1'b0;
    rd_chk(wdp_pkg::OFS_CONTROL, 8'h01);
    // timeout while asleep wakes instead
    kick(0);
    expect_to(2 * BC + 1, 2'b01);
    in_sleep <= 1'b0;
    // each other clear source restarts the count, tap kept over sys reset
    for (int k = 1; k < 4; k++) begin
      kick(0);
      repeat (5) cyc();
      kick(k);
      expect_to(2 * BC + 1, 2'b10);
    end
    // software enable once config enable is cleared
    wr(wdp_pkg::OFS_CFG_ENABLE, 8'h00);
    chk(rc_en, 1'b0);
    wr(wdp_pkg::OFS_CONTROL, 8'h01);
    chk(rc_en, 1'b1);
    kick(0);
    expect_to(2 * BC + 1, 2'b10);
    wr(wdp_pkg::OFS_CFG_ENABLE, 8'h01);
    wr(wdp_pkg::OFS_CONTROL, 8'h00);
    chk(rc_en, 1'b0);
    rd_chk(wdp_pkg::OFS_STATUS, 8'h08);
    stop_test();
  end
endmodule

// File: test/wdp_watchdog_checker.sv
// checker: timing relations seen at the watchdog ports
// assumes one clock domain, rst async active high, bound below
`timescale 1ns/10ps

module wdp_watchdog_checker #(
  parameter int BASE_CYCLES = 4
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic sys_reset,
  input wire logic [21:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic sleep_instr,
  input wire logic clear_watchdog_instr,
  input wire logic clock_fail,
  input wire logic in_sleep,
  input wire logic low_voltage_detect,
  input wire logic internal_rc_clock_en,
  input wire logic regulator_lowpower,
  input wire logic watchdog_reset,
  input wire logic watchdog_wake
);
  // ==========================================================
  // common clocking
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  wire logic to_any = watchdog_reset | watchdog_wake; // either timeout pulse

  // ==========================================================
  // assertions
  property p_rd_idle; !$past(reg_rd) |-> reg_rdata == 8'h00; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
  property p_one_kind; to_any |-> watchdog_reset != watchdog_wake; endproperty
  a_one_kind: assert property (p_one_kind) else $error("both pulses at once");
  property p_gap; to_any |=> !to_any [*3]; endproperty
  a_gap: assert property (p_gap) else $error("timeout pulses too close");
  property p_clr; (sleep_instr || clear_watchdog_instr) |-> ##2 !to_any [*3]; endproperty
  a_clr: assert property (p_clr) else $error("timeout soon after clear");
  property p_fail; clock_fail |-> ##2 !to_any [*3]; endproperty
  a_fail: assert property (p_fail) else $error("timeout soon after clock fail");
  property p_enabled; to_any |-> $past(internal_rc_clock_en); endproperty
  a_enabled: assert property (p_enabled) else $error("timeout while off");
  property p_reg_lp; regulator_lowpower |-> in_sleep; endproperty
  a_reg_lp: assert property (p_reg_lp) else $error("low power while awake");
  property p_lvd; low_voltage_detect [*4] |-> !regulator_lowpower; endproperty
  a_lvd: assert property (p_lvd) else $error("low power kept on low voltage");
  property p_wake; watchdog_wake |-> $past(in_sleep); endproperty
  a_wake: assert property (p_wake) else $error("wake while awake");
  property p_awake; watchdog_reset |-> !$past(in_sleep); endproperty
  a_awake: assert property (p_awake) else $error("reset while asleep");
endmodule

bind wdp_watchdog wdp_watchdog_checker #(.BASE_CYCLES(BASE_CYCLES)) u_chk (
  .clk(clk), .rst(rst), .sys_reset(sys_reset), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .sleep_instr(sleep_instr), .clear_watchdog_instr(clear_watchdog_instr),
  .clock_fail(clock_fail), .in_sleep(in_sleep), .low_voltage_detect(low_voltage_detect),
  .internal_rc_clock_en(internal_rc_clock_en), .regulator_lowpower(regulator_lowpower),
  .watchdog_reset(watchdog_reset), .watchdog_wake(watchdog_wake)
);
